// file: rtl/nefu_top.sv
// Network event flags, masks, tick counter and APB register slave.
`timescale 1ns/1ps
module nefu_top
    import nefu_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Global events.
    input wire logic wakePacketEvt,
    input wire logic v6PortUnreachEvt,
    input wire logic [127:0] v6UnreachAddr,
    input wire logic [15:0] v6UnreachPort,
    input wire logic v4AddrClashEvt,
    input wire logic v4PortUnreachEvt,
    input wire logic [31:0] v4UnreachAddr,
    input wire logic [15:0] v4UnreachPort,
    input wire logic pppSessionEndEvt,
    // Socket event flags, eight bits per socket.
    input wire logic [63:0] socketEventFlags,
    // Socket-less events.
    input wire logic nosockTimeoutEvt,
    input wire logic addrResolveV4Evt,
    input wire logic echoV4Evt,
    input wire logic addrResolveV6Evt,
    input wire logic echoV6Evt,
    input wire logic dupAddrCheckEvt,
    input wire logic routerSolicitEvt,
    input wire logic routerAdvertEvt,
    // Router advertisement prefix data.
    input wire logic [7:0] raOpt1Type,
    input wire logic [7:0] raOpt2Type,
    input wire logic [7:0] raPrefixLen,
    input wire logic [7:0] raPrefixFlags,
    input wire logic [31:0] raValidLife,
    input wire logic [31:0] raPrefLife,
    input wire logic [127:0] raPrefix,
    // Tick counter and alert.
    output logic [15:0] tickCount,
    output logic hostAlertN
);
    typedef struct packed {
        logic [15:0] tick;
        logic [13:0] pre;
        logic [7:0] gMask;
        logic [7:0] sMask;
        logic [7:0] nMask;
        logic alert_master_enable;
        logic [7:0] summary;
        logic [127:0] v6Addr;
        logic [15:0] v6Port;
        logic [31:0] v4Addr;
        logic [15:0] v4Port;
        logic [7:0] pLen;
        logic [7:0] pFlag;
        logic [31:0] vLife;
        logic [31:0] pLife;
        logic [127:0] pAddr;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic alertN;
    } nefu_state_t;

    nefu_state_t state_r;
    nefu_state_t state_nxt;

    logic [7:0] gFlags;
    logic [7:0] nFlags;
    logic [7:0] gSet;
    logic [7:0] nSet;
    logic [7:0] gClr;
    logic [7:0] nClr;
    logic [13:0] idx;
    logic aligned;
    logic setup;
    logic wrAcc;
    logic hit;
    logic [31:0] rd;
    logic [13:0] sub;
    logic optsOk;
    logic pending;

    // ========================================================
    // Event set vectors.
    always_comb begin
        gSet = RESET_BYTE;
        gSet[BIT_WAKE] = wakePacketEvt;
        gSet[BIT_V6_PORT_UNREACH_FLAG] = v6PortUnreachEvt;
        gSet[BIT_CLASH] = v4AddrClashEvt;
        gSet[BIT_V4_PORT_UNREACH_FLAG] = v4PortUnreachEvt;
        gSet[BIT_PPP] = pppSessionEndEvt;
        nSet = RESET_BYTE;
        nSet[BIT_NOSOCK_TIMEOUT_FLAG] = nosockTimeoutEvt;
        nSet[BIT_ADDR_RESOLVE_V4_DONE] = addrResolveV4Evt;
        nSet[BIT_ECHO_V4_DONE] = echoV4Evt;
        nSet[BIT_ADDR_RESOLVE_V6_DONE] = addrResolveV6Evt;
        nSet[BIT_ECHO_V6_DONE] = echoV6Evt;
        nSet[BIT_DAD] = dupAddrCheckEvt;
        nSet[BIT_RS] = routerSolicitEvt;
        nSet[BIT_RA] = routerAdvertEvt;
    end

    // ========================================================
    // APB decode.
    assign idx = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && state_r.ready && pwrite;

    always_comb begin
        gClr = RESET_BYTE;
        nClr = RESET_BYTE;
        if (wrAcc && aligned && idx == IDX_GCLR) begin
            gClr = pwdata[7:0];
        end
        if (wrAcc && aligned && idx == IDX_NCLR) begin
            nClr = pwdata[7:0];
        end
    end

    // ========================================================
    // Flag banks.
    nefu_flag_bank #(
        .IMPL(GLOBAL_IMPL)
    ) u_global (
        .clk(clk),
        .rst(rst),
        .setIn(gSet),
        .clrIn(gClr),
        .flags(gFlags)
    );

    nefu_flag_bank #(
        .IMPL(NOSOCK_IMPL)
    ) u_nosock (
        .clk(clk),
        .rst(rst),
        .setIn(nSet),
        .clrIn(nClr),
        .flags(nFlags)
    );

    // ========================================================
    // Read multiplexer.
    always_comb begin
        rd = RESET_WORD;
        hit = 1'b1;
        sub = idx - IDX_V6ADDR;
        if (idx >= IDX_V6ADDR && idx < IDX_V6ADDR + WIDE_WORDS) begin
            sub = idx - IDX_V6ADDR;
            rd = state_r.v6Addr[7'(96 - 32 * int'(sub[1:0])) +: 32];
        end else if (idx >= IDX_PADDR && idx < IDX_PADDR + WIDE_WORDS) begin
            sub = idx - IDX_PADDR;
            rd = state_r.pAddr[7'(96 - 32 * int'(sub[1:0])) +: 32];
        end else begin
            case (idx)
                IDX_SYS_CFG: rd[BIT_IEN] = state_r.alert_master_enable;
                IDX_TICK: rd[15:0] = state_r.tick;
                IDX_TICK_CLR: rd = RESET_WORD;
                IDX_GFLAGS: rd[7:0] = gFlags & GLOBAL_IMPL;
                IDX_SUMMARY: rd[7:0] = state_r.summary;
                IDX_NFLAGS: rd[7:0] = nFlags;
                IDX_GMASK: rd[7:0] = state_r.gMask;
                IDX_GCLR: rd = RESET_WORD;
                IDX_SMASK: rd[7:0] = state_r.sMask;
                IDX_NMASK: rd[7:0] = state_r.nMask;
                IDX_NCLR: rd = RESET_WORD;
                IDX_V6PORT: rd[15:0] = state_r.v6Port;
                IDX_V4ADDR: rd = state_r.v4Addr;
                IDX_V4PORT: rd[15:0] = state_r.v4Port;
                IDX_PLEN: rd[7:0] = state_r.pLen;
                IDX_PFLAG: rd[7:0] = state_r.pFlag;
                IDX_VLIFE: rd = state_r.vLife;
                IDX_PLIFE: rd = state_r.pLife;
                default: hit = 1'b0;
            endcase
        end
        if (!aligned) begin
            hit = 1'b0;
            rd = RESET_WORD;
        end
    end

    // ========================================================
    // Next state.
    assign optsOk = (raOpt1Type == OPT_SRC_LINK) &&
        (raOpt2Type == OPT_PREFIX);

    always_comb begin
        state_nxt = state_r;
        pending = 1'b0;

        if (state_r.pre == 14'(TICK_DIV - 1)) begin
            state_nxt.pre = 14'h0000;
            state_nxt.tick = state_r.tick + 16'h0001;
        end else begin
            state_nxt.pre = state_r.pre + 14'h0001;
        end

        for (int n = 0; n < 8; n++) begin
            state_nxt.summary[n] = |socketEventFlags[8 * n +: 8];
        end

        if (v6PortUnreachEvt) begin
            state_nxt.v6Addr = v6UnreachAddr;
            state_nxt.v6Port = v6UnreachPort;
        end
        if (v4PortUnreachEvt) begin
            state_nxt.v4Addr = v4UnreachAddr;
            state_nxt.v4Port = v4UnreachPort;
        end

        if ((routerSolicitEvt || routerAdvertEvt) && optsOk) begin
            state_nxt.pLen = raPrefixLen;
            state_nxt.pFlag = raPrefixFlags;
            state_nxt.vLife = raValidLife;
            state_nxt.pLife = raPrefLife;
            state_nxt.pAddr = raPrefix;
        end

        // APB answer, one wait-free access cycle.
        state_nxt.ready = setup;
        state_nxt.err = setup && !hit;
        state_nxt.rdata = (setup && !pwrite) ? rd : RESET_WORD;

        if (wrAcc && aligned) begin
            case (idx)
                IDX_SYS_CFG: state_nxt.alert_master_enable = pwdata[BIT_IEN];
                IDX_TICK_CLR: begin
                    state_nxt.tick = 16'h0000;
                    state_nxt.pre = 14'h0000;
                end
                IDX_GMASK: state_nxt.gMask = pwdata[7:0] & GLOBAL_IMPL;
                IDX_SMASK: state_nxt.sMask = pwdata[7:0];
                IDX_NMASK: state_nxt.nMask = pwdata[7:0];
                default: state_nxt.alert_master_enable = state_r.alert_master_enable;
            endcase
        end

        pending = |(gFlags & state_r.gMask) |
            |(state_r.summary & state_r.sMask) |
            |(nFlags & state_r.nMask);
        state_nxt.alertN = !(state_r.alert_master_enable && pending);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
            state_r.alertN <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ========================================================
    // Outputs.
    assign prdata = state_r.rdata;
    assign pready = state_r.ready;
    assign pslverr = state_r.err;
    assign tickCount = state_r.tick;
    assign hostAlertN = state_r.alertN;
endmodule : nefu_top

// file: rtl/nefu_pkg.sv
// Package with register indices, field layouts and timing constants.
// Behaviour
// - Any write to tick clear zeroes tick counter.
// - Tick counter advances once every 100 microseconds.
// - Wake packet sets global flag bit 7.
// - IPv6 unreachable sets bit 4, stores address, port.
// - IPv4 address clash sets global flag bit 2.
// - IPv4 unreachable sets bit 1, stores address, port.
// - PPPoE session end sets global flag bit 0.
// - Summary bit n shows socket n flags non-zero.
// - Socket-less command timeout sets bit 7.
// - IPv4 resolution reply sets socket-less bit 6.
// - IPv4 echo reply sets socket-less bit 5.
// - IPv6 resolution reply sets socket-less bit 4.
// - IPv6 echo reply sets socket-less bit 3.
// - Duplicate address answer sets socket-less bit 2.
// - Solicited router advert sets socket-less bit 1.
// - Gateway all-nodes router advert sets bit 0.
// - Router advert flags capture prefix data registers.
// - Prefix capture valid only with options 0x01, 0x03.
// - Global mask bits enable matching global flags.
// - Master enable gates active-low alert line.
package nefu_pkg;
    // ========================================================
    // Register indices; byte address is four times the index.
    localparam logic [13:0] IDX_SYS_CFG = 14'h2005;
    localparam logic [13:0] IDX_TICK = 14'h2016;
    localparam logic [13:0] IDX_TICK_CLR = 14'h2020;
    localparam logic [13:0] IDX_GFLAGS = 14'h2100;
    localparam logic [13:0] IDX_SUMMARY = 14'h2101;
    localparam logic [13:0] IDX_NFLAGS = 14'h2102;
    localparam logic [13:0] IDX_GMASK = 14'h2104;
    localparam logic [13:0] IDX_GCLR = 14'h2108;
    localparam logic [13:0] IDX_SMASK = 14'h2114;
    localparam logic [13:0] IDX_NMASK = 14'h2124;
    localparam logic [13:0] IDX_NCLR = 14'h2128;
    localparam logic [13:0] IDX_V6ADDR = 14'h2200;
    localparam logic [13:0] IDX_V6PORT = 14'h2204;
    localparam logic [13:0] IDX_V4ADDR = 14'h2205;
    localparam logic [13:0] IDX_V4PORT = 14'h2206;
    localparam logic [13:0] IDX_PLEN = 14'h2207;
    localparam logic [13:0] IDX_PFLAG = 14'h2208;
    localparam logic [13:0] IDX_VLIFE = 14'h2209;
    localparam logic [13:0] IDX_PLIFE = 14'h220A;
    localparam logic [13:0] IDX_PADDR = 14'h220B;
    localparam logic [13:0] WIDE_WORDS = 14'h0004;

    // ========================================================
    // Field positions.
    localparam int BIT_WAKE = 7;
    localparam int BIT_V6_PORT_UNREACH_FLAG = 4;
    localparam int BIT_CLASH = 2;
    localparam int BIT_V4_PORT_UNREACH_FLAG = 1;
    localparam int BIT_PPP = 0;
    localparam int BIT_NOSOCK_TIMEOUT_FLAG = 7;
    localparam int BIT_ADDR_RESOLVE_V4_DONE = 6;
    localparam int BIT_ECHO_V4_DONE = 5;
    localparam int BIT_ADDR_RESOLVE_V6_DONE = 4;
    localparam int BIT_ECHO_V6_DONE = 3;
    localparam int BIT_DAD = 2;
    localparam int BIT_RS = 1;
    localparam int BIT_RA = 0;
    localparam int BIT_IEN = 7;
    localparam logic [7:0] GLOBAL_IMPL = 8'h97;
    localparam logic [7:0] NOSOCK_IMPL = 8'hFF;

    // ========================================================
    // Values after reset and option types.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [7:0] OPT_SRC_LINK = 8'h01;
    localparam logic [7:0] OPT_PREFIX = 8'h03;

    // ========================================================
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
endpackage : nefu_pkg

// file: rtl/nefu_flag_bank.sv
// Eight sticky event flags with write-one-to-clear and set priority.
`timescale 1ns/1ps
module nefu_flag_bank
    import nefu_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hFF
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Events and clears.
    input wire logic [7:0] setIn,
    input wire logic [7:0] clrIn,
    // Flag state.
    output logic [7:0] flags
);
    typedef struct packed {
        logic [7:0] flags;
    } nefu_bank_t;

    nefu_bank_t state_r;
    nefu_bank_t state_nxt;

    // ========================================================
    // Flag update.
    always_comb begin
        state_nxt = state_r;
        state_nxt.flags = ((state_r.flags & ~clrIn) | setIn) & IMPL;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r.flags <= RESET_BYTE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flags = state_r.flags;
endmodule : nefu_flag_bank

// file: tb/nefu_top_asserts.sv
// Concurrent checks on the event flag unit ports.
`timescale 1ns/1ps
module nefu_top_asserts
    import nefu_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    // Events and outputs.
    input wire logic wakePacketEvt, v6PortUnreachEvt, v4AddrClashEvt,
    input wire logic v4PortUnreachEvt, pppSessionEndEvt, nosockTimeoutEvt,
    input wire logic addrResolveV4Evt, echoV4Evt, addrResolveV6Evt,
    input wire logic echoV6Evt, dupAddrCheckEvt, routerSolicitEvt,
    input wire logic routerAdvertEvt, hostAlertN,
    input wire logic [63:0] socketEventFlags,
    input wire logic [15:0] tickCount
);
    logic wrAcc;
    logic rdAcc;
    logic cause;
    logic [31:0] summ;
    assign wrAcc = psel && penable && pready && pwrite;
    assign rdAcc = psel && penable && pready && !pwrite;
    assign cause = wrAcc || (|socketEventFlags) || wakePacketEvt
        || v6PortUnreachEvt || v4AddrClashEvt || v4PortUnreachEvt
        || pppSessionEndEvt || nosockTimeoutEvt || addrResolveV4Evt
        || echoV4Evt || addrResolveV6Evt || echoV6Evt || dupAddrCheckEvt
        || routerSolicitEvt || routerAdvertEvt;
    always_comb begin
        summ = 32'h0;
        for (int n = 0; n < 8; n++) begin
            summ[n] = |socketEventFlags[8*n +: 8];
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_tick_clear: assert property (wrAcc
        && paddr == {IDX_TICK_CLR, 2'b00} |=> tickCount == 16'h0000)
        else $error("tick count not cleared");
    a_tick_step: assert property ($changed(tickCount)
        && tickCount != 16'h0000 |-> tickCount == $past(tickCount) + 16'h1)
        else $error("tick count jumped");
    a_tick_gap: assert property ($changed(tickCount)
        && tickCount != 16'h0000 |=> $stable(tickCount)
        || tickCount == 16'h0000) else $error("tick count too fast");
    a_summary_read: assert property (rdAcc
        && paddr == {IDX_SUMMARY, 2'b00}
        && $past(socketEventFlags, 2) == socketEventFlags
        && $past(socketEventFlags) == socketEventFlags |-> prdata == summ)
        else $error("summary read wrong");
    a_resv_zero: assert property (rdAcc && (paddr == {IDX_GFLAGS, 2'b00}
        || paddr == {IDX_GMASK, 2'b00})
        |-> (prdata & ~{24'h0, GLOBAL_IMPL}) == 32'h0)
        else $error("reserved bits not zero");
    a_ro_write: assert property (psel && !penable && pwrite
        && paddr == {IDX_GFLAGS, 2'b00} |=> pready && !pslverr ##1 !pready)
        else $error("flag write answer wrong");
    a_alert_fall: assert property ($fell(hostAlertN)
        |-> $past(cause, 2)) else $error("alert without cause");
    a_alert_rise: assert property ($rose(hostAlertN) |-> $past(wrAcc, 2)
        || $past(socketEventFlags, 2) != $past(socketEventFlags, 3))
        else $error("alert released without clear");
endmodule : nefu_top_asserts

bind nefu_top nefu_top_asserts u_nefu_top_asserts (.*);

// file: tb/nefu_host_model.sv
// Host processor model acting as APB master.
`timescale 1ns/1ps
module nefu_host_model
    import nefu_pkg::*;
(
    // Clock.
    input wire logic clk,
    // APB master.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [15:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // One transfer, entered just after a rising edge.
    task automatic xfer(input logic w, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic clear(input logic ns, input logic [7:0] m);
        logic [31:0] q;
        logic e;
        xfer(1'b1, {ns ? IDX_NCLR : IDX_GCLR, 2'b00}, {24'h0, m}, q, e);
    endtask : clear
endmodule : nefu_host_model

// file: tb/tb_top.sv
// Self-checking testbench for the event flag unit.
`timescale 1ns/1ps
module tb_top
    import nefu_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, hostAlertN, e;
    logic [15:0] paddr, tickCount, v6Port, v4Port;
    logic [31:0] pwdata, prdata, v4Addr, vLife, pLife, q, a4, pt, pl, vl;
    logic [127:0] v6Addr, raPfx, a6;
    logic [63:0] sock, s;
    logic [4:0] gEv;
    logic [7:0] nEv, opt1, opt2, pLen, pFlg;
    int errors, checked;
    localparam logic [7:0] GB [5] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h80};
    localparam logic [13:0] RI [4] = '{IDX_GFLAGS, IDX_SUMMARY, IDX_NFLAGS,
        IDX_GMASK};

    nefu_host_model u_nefu_host_model (.clk(clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    nefu_top #(.TICK_DIV(8)) u_nefu_top (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wakePacketEvt(gEv[4]), .v6PortUnreachEvt(gEv[3]),
        .v6UnreachAddr(v6Addr), .v6UnreachPort(v6Port),
        .v4AddrClashEvt(gEv[2]), .v4PortUnreachEvt(gEv[1]),
        .v4UnreachAddr(v4Addr), .v4UnreachPort(v4Port),
        .pppSessionEndEvt(gEv[0]), .socketEventFlags(sock),
        .nosockTimeoutEvt(nEv[7]), .addrResolveV4Evt(nEv[6]),
        .echoV4Evt(nEv[5]), .addrResolveV6Evt(nEv[4]), .echoV6Evt(nEv[3]),
        .dupAddrCheckEvt(nEv[2]), .routerSolicitEvt(nEv[1]),
        .routerAdvertEvt(nEv[0]), .raOpt1Type(opt1), .raOpt2Type(opt2),
        .raPrefixLen(pLen), .raPrefixFlags(pFlg), .raValidLife(vLife),
        .raPrefLife(pLife), .raPrefix(raPfx), .tickCount(tickCount),
        .hostAlertN(hostAlertN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim();
    end

    task automatic end_sim();
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [127:0] v, x);
        checked++;
        if (v !== x) begin
            errors++;
            $display("BAD %s exp %h got %h", n, x, v);
        end
    endtask : chk
    task automatic rd(input logic [13:0] i, input logic [31:0] x, string n);
        u_nefu_host_model.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
        chk(n, q, x);
    endtask : rd
    task automatic wr(input logic [13:0] i, input logic [31:0] d);
        u_nefu_host_model.xfer(1'b1, {i, 2'b00}, d, q, e);
    endtask : wr
    task automatic pulse(input logic [4:0] g, input logic [7:0] n);
        gEv <= g;
        nEv <= n;
        @(posedge clk);
        gEv <= 5'h00;
        nEv <= 8'h00;
        @(posedge clk);
    endtask : pulse
    function automatic logic [31:0] sumOf(input logic [63:0] f);
        sumOf = 32'h0;
        for (int n = 0; n < 8; n++) sumOf[n] = |f[8*n +: 8];
    endfunction : sumOf

    initial begin
        rst = 1'b1;
        {gEv, nEv, opt1, opt2, pLen, pFlg, sock} = '0;
        {v6Addr, raPfx, v4Addr, vLife, pLife, v6Port, v4Port} = '0;
        void'($urandom(51999));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (RI[k]) rd(RI[k], 32'h0, "reset");
        for (int j = 0; j < 5; j++) begin
            pulse(5'h01 << j, 8'h00);
            wr(IDX_GFLAGS, 32'h0);
            rd(IDX_GFLAGS, {24'h0, GB[j]}, "gflag");
            u_nefu_host_model.clear(1'b0, GB[j]);
            rd(IDX_GFLAGS, 32'h0, "gclr");
        end
        a6 = {$urandom, $urandom, $urandom, $urandom};
        a4 = $urandom;
        pt = $urandom;
        {v6Addr, v4Addr, v6Port, v4Port} <= {a6, a4, pt};
        pulse(5'h0A, 8'h00);
        {v6Addr, v4Addr, v6Port, v4Port} <= ~{a6, a4, pt};
        for (int w = 0; w < 4; w++) begin
            rd(IDX_V6ADDR + 14'(w), a6[127-32*w -: 32], "v6addr");
            rd(IDX_PADDR + 14'(w), 32'h0, "noprefix");
        end
        rd(IDX_V6PORT, {16'h0, pt[31:16]}, "v6port");
        rd(IDX_V4ADDR, a4, "v4addr");
        rd(IDX_V4PORT, {16'h0, pt[15:0]}, "v4port");
        u_nefu_host_model.clear(1'b0, 8'h12);
        for (int i = 0; i < 8; i++) begin
            pulse(5'h00, 8'h01 << i);
            rd(IDX_NFLAGS, 32'h1 << i, "nflag");
            u_nefu_host_model.clear(1'b1, 8'h01 << i);
        end
        rd(IDX_NFLAGS, 32'h0, "nclr");
        pl = $urandom;
        vl = $urandom;
        {opt1, opt2, raPfx, pLen, pFlg, vLife, pLife} <=
            {OPT_SRC_LINK, OPT_PREFIX, a6, pl[15:0], vl, ~vl};
        pulse(5'h00, 8'h01);
        {opt2, raPfx, pLen, vLife} <= {8'h04, ~a6, ~pl[7:0], pl};
        pulse(5'h00, 8'h02);
        rd(IDX_NFLAGS, 32'h3, "raflags");
        rd(IDX_PLEN, {24'h0, pl[15:8]}, "plen");
        rd(IDX_PFLAG, {24'h0, pl[7:0]}, "pflag");
        rd(IDX_VLIFE, vl, "vlife");
        rd(IDX_PLIFE, ~vl, "plife");
        for (int w = 0; w < 4; w++) begin
            rd(IDX_PADDR + 14'(w), a6[127-32*w -: 32], "paddr");
        end
        u_nefu_host_model.clear(1'b1, 8'h03);
        for (int k = 0; k < 8; k++) begin
            s = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
            sock <= s;
            repeat (3) @(posedge clk);
            rd(IDX_SUMMARY, sumOf(s), "summary");
        end
        sock <= 64'h0;
        wr(IDX_GMASK, 32'hFF);
        rd(IDX_GMASK, {24'h0, GLOBAL_IMPL}, "gmask");
        pulse(5'h10, 8'h00);
        repeat (3) @(posedge clk);
        chk("alert ien off", hostAlertN, 1'b1);
        wr(IDX_SYS_CFG, 32'h80);
        repeat (2) @(posedge clk);
        chk("alert ien on", hostAlertN, 1'b0);
        wr(IDX_GMASK, 32'h7F);
        repeat (2) @(posedge clk);
        chk("alert masked", hostAlertN, 1'b1);
        sock <= 64'h0100;
        wr(IDX_SMASK, 32'h02);
        repeat (2) @(posedge clk);
        chk("alert socket", hostAlertN, 1'b0);
        sock <= 64'h0;
        pulse(5'h00, 8'h20);
        wr(IDX_NMASK, 32'h20);
        repeat (2) @(posedge clk);
        chk("alert nosock", hostAlertN, 1'b0);
        u_nefu_host_model.clear(1'b1, 8'h20);
        repeat (2) @(posedge clk);
        chk("alert clear", hostAlertN, 1'b1);
        u_nefu_host_model.xfer(1'b0, 16'h0000, 32'h0, q, e);
        chk("unmapped", {e, q}, 33'h100000000);
        wr(IDX_TICK_CLR, $urandom);
        repeat (27) @(posedge clk);
        chk("tick", tickCount, 16'h0003);
        end_sim();
    end
endmodule : tb_top
